// ### rtl/urc_defines.svh
// timing and count constants for the ultrasonic ranging control block
`ifndef URC_DEFINES_SVH
`define URC_DEFINES_SVH

// system clock rate
`define URC_CLK_HZ          25000000
// internal oscillator and transmit frequency, in hertz
`define URC_OSC_HZ          49400
// system clock cycles in one oscillator period (rounded down)
`define URC_OSC_DIV_CYC     (`URC_CLK_HZ / `URC_OSC_HZ)
// system clock cycles in the high half of one oscillator period
`define URC_OSC_HALF_CYC    (`URC_OSC_DIV_CYC / 2)

// transmit burst length in oscillator periods
`define URC_BURST_PULSES    16

// internal blanking interval in microseconds
`define URC_BLANK_US        2380
// blanking interval in oscillator periods, rounded up as a least time
`define URC_BLANK_OSC_CYC   ((`URC_BLANK_US * `URC_OSC_HZ + 999999) / 1000000)

// counter widths
`define URC_PHASE_W         9
`define URC_PULSE_W         5
`define URC_BLANK_W         8

`endif

// ### rtl/urc_pkg.sv
// types shared by the ultrasonic ranging control block
package urc_pkg;

  // cycle sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TX   = 3'b010,
    ST_RX   = 3'b100
  } urc_state_e;

endpackage : urc_pkg

// ### rtl/urc_burst_osc.sv
// gated internal oscillator: runs only while enabled, gives a level and a period-end tick
`timescale 1ns/1ps
`include "urc_defines.svh"

module urc_burst_osc
  import urc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic oscEnable,
  output logic      oscLevel,
  output logic      oscTick
);

  localparam logic [`URC_PHASE_W-1:0] PHASE_LAST = `URC_PHASE_W'(`URC_OSC_DIV_CYC - 1);
  localparam logic [`URC_PHASE_W-1:0] PHASE_HALF = `URC_PHASE_W'(`URC_OSC_HALF_CYC);

  logic                    running_q;
  logic [`URC_PHASE_W-1:0] phase_q;

  // stopping clears the phase so every start begins on a fresh high half
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      running_q <= 1'b0;
    end else begin
      running_q <= oscEnable;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      phase_q <= '0;
    end else if (!oscEnable) begin
      phase_q <= '0;
    end else if (running_q) begin
      if (phase_q == PHASE_LAST) begin
        phase_q <= '0;
      end else begin
        phase_q <= phase_q + `URC_PHASE_W'(1);
      end
    end
  end

  assign oscLevel = running_q && (phase_q < PHASE_HALF);
  assign oscTick  = running_q && (phase_q == PHASE_LAST);

endmodule // urc_burst_osc

// ### rtl/urc_ranging_ctrl.sv
// cycle sequencer of the ultrasonic ranging control block: burst, blanking, echo flag
//
// Summary of operation
// - a trigger rise starts a burst of sixteen transducer pulses at 49.4 kHz.
// - after the sixteenth pulse the sequencer leaves transmit and waits for an echo in receive.
// - the internal oscillator runs only while the trigger is high and is shown on its output pin.
// - all transmit and receive intervals, blanking included, count from the trigger rise.
// - the receive input is ignored for 2.38 ms after the trigger rise so ringing is not an echo.
// - a high blanking override ends blanking at once and echoes are accepted from then on while in receive.
// - the first accepted echo raises the detected flag and holds it until a re-arm pulse or a trigger fall clears it.
`timescale 1ns/1ps
`include "urc_defines.svh"

module urc_ranging_ctrl
  import urc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic cycleTrigger,
  input  wire logic receiveInput,
  input  wire logic blanking_override,
  input  wire logic echo_rearm,
  output logic      transducer_drive,
  output logic      burst_clock_out,
  output logic      echoDetected
);

  localparam logic [`URC_PULSE_W-1:0] PULSE_LAST = `URC_PULSE_W'(`URC_BURST_PULSES - 1);
  localparam logic [`URC_BLANK_W-1:0] BLANK_LAST = `URC_BLANK_W'(`URC_BLANK_OSC_CYC - 1);

  urc_state_e              state_q;
  urc_state_e              state_d;
  logic                    trigPrev_q;
  logic                    trigRise;
  logic                    oscLevel;
  logic                    oscTick;
  logic [`URC_PULSE_W-1:0] pulseCnt_q;
  logic [`URC_BLANK_W-1:0] blankCnt_q;
  logic                    blankDone_q;
  logic                    blankOpen;
  logic                    echoAccept;
  logic                    transducerDrive_q;
  logic                    burstClock_q;
  logic                    echoDetected_q;

  // the oscillator is gated straight from the trigger level
  urc_burst_osc u_osc (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .oscEnable (cycleTrigger),
    .oscLevel  (oscLevel),
    .oscTick   (oscTick)
  );

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      trigPrev_q <= 1'b0;
    end else begin
      trigPrev_q <= cycleTrigger;
    end
  end

  assign trigRise = cycleTrigger && !trigPrev_q;

  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (trigRise) begin
          state_d = ST_TX;
        end
      end
      ST_TX: begin
        if (oscTick && (pulseCnt_q == PULSE_LAST)) begin
          state_d = ST_RX;
        end
      end
      ST_RX: begin
        state_d = ST_RX;
      end
    endcase
    if (!cycleTrigger) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // burst pulses are whole oscillator periods
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pulseCnt_q <= '0;
    end else if (trigRise) begin
      pulseCnt_q <= '0;
    end else if ((state_q == ST_TX) && oscTick) begin
      pulseCnt_q <= pulseCnt_q + `URC_PULSE_W'(1);
    end
  end

  // blanking runs from the trigger rise, overlapping the burst
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blankCnt_q <= '0;
    end else if (trigRise) begin
      blankCnt_q <= '0;
    end else if (cycleTrigger && oscTick && !blankDone_q) begin
      blankCnt_q <= blankCnt_q + `URC_BLANK_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      blankDone_q <= 1'b0;
    end else if (trigRise || !cycleTrigger) begin
      blankDone_q <= 1'b0;
    end else if (blanking_override) begin
      blankDone_q <= 1'b1;
    end else if (oscTick && (blankCnt_q == BLANK_LAST)) begin
      blankDone_q <= 1'b1;
    end
  end

  // override acts combinationally so it opens the receive path in the same cycle
  assign blankOpen  = blankDone_q || blanking_override;
  assign echoAccept = (state_q == ST_RX) && blankOpen && receiveInput;

  // re-arm takes priority over an accepted echo in the flag register, so it beats a coincident echo
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      echoDetected_q <= 1'b0;
    end else if (!cycleTrigger) begin
      echoDetected_q <= 1'b0;
    end else if (echo_rearm) begin
      echoDetected_q <= 1'b0;
    end else if (echoAccept) begin
      echoDetected_q <= 1'b1;
    end
  end

  // outputs registered; one cycle behind the oscillator phase
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      transducerDrive_q <= 1'b0;
    end else begin
      transducerDrive_q <= (state_q == ST_TX) && oscLevel;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      burstClock_q <= 1'b0;
    end else begin
      burstClock_q <= oscLevel;
    end
  end

  assign transducer_drive = transducerDrive_q;
  assign burst_clock_out  = burstClock_q;
  assign echoDetected     = echoDetected_q;

  chk_burst_start_drive: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_IDLE) && trigRise ##1 cycleTrigger |=> transducerDrive_q)
    else $error("burst did not start after trigger rise");

  chk_burst_end_rx: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    (state_q == ST_TX) && oscTick && (pulseCnt_q == PULSE_LAST) && cycleTrigger |=> (state_q == ST_RX))
    else $error("no move to receive after last pulse");

  chk_burst_pulse_count: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(state_q == ST_RX) |-> (pulseCnt_q == `URC_PULSE_W'(`URC_BURST_PULSES)))
    else $error("burst length is not sixteen periods");

  chk_osc_gated_off: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !cycleTrigger ##1 !cycleTrigger |=> !burst_clock_out && !transducer_drive)
    else $error("oscillator output active with trigger low");

  chk_blank_ignores_rx: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !echoDetected_q && !blankDone_q && !blanking_override |=> !echoDetected_q)
    else $error("echo taken during blanking");

  chk_override_opens: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    blanking_override && (state_q == ST_RX) && receiveInput && cycleTrigger && !echo_rearm |=> echoDetected_q)
    else $error("override did not open the receive path");

  chk_echo_held: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    echoDetected_q && cycleTrigger && !echo_rearm |=> echoDetected_q)
    else $error("echo flag dropped without re-arm");

  chk_rearm_clears: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    echo_rearm |=> !echoDetected_q)
    else $error("re-arm did not clear the echo flag");

  chk_abort_idle: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !cycleTrigger |=> (state_q == ST_IDLE) && !echoDetected_q)
    else $error("trigger fall did not abort the cycle");

  chk_blank_length: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    $rose(blankDone_q) && !$past(blanking_override) |-> (blankCnt_q == `URC_BLANK_W'(`URC_BLANK_OSC_CYC)))
    else $error("blanking did not last its period count");

endmodule // urc_ranging_ctrl

// ### tb/urc_host_model.sv
// host-side model: drives trigger, echo, override and re-arm on falling edges
`timescale 1ns/1ps

module urc_host_model #(
  parameter int SETTLE_CYC = 100
) (
  input  wire logic clk_sys,
  output logic      cycleTrigger,
  output logic      receiveInput,
  output logic      blanking_override,
  output logic      echo_rearm
);
  initial begin
    cycleTrigger      = 1'b0;
    receiveInput      = 1'b0;
    blanking_override = 1'b0;
    echo_rearm        = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // settling shortened from milliseconds to keep the run short
  task automatic settle();
    idle(SETTLE_CYC);
  endtask

  // cycle spacing also shortened; trigger stays high until the flag rose
  task automatic trig(input logic v);
    @(negedge clk_sys);
    cycleTrigger = v;
  endtask

  task automatic echo(input int len);
    @(negedge clk_sys);
    receiveInput = 1'b1;
    idle(len);
    receiveInput = 1'b0;
  endtask

  task automatic override(input logic v);
    @(negedge clk_sys);
    blanking_override = v;
  endtask

  // an echo arrives mid pulse; it must not set the flag
  task automatic rearm(input int len);
    @(negedge clk_sys);
    echo_rearm = 1'b1;
    idle(len / 2);
    receiveInput = 1'b1;
    idle(3);
    receiveInput = 1'b0;
    idle(len / 2);
    echo_rearm = 1'b0;
  endtask
endmodule // urc_host_model

// ### tb/ultrasonic_ranging_control_test.sv
// self-checking bench for the ultrasonic ranging control sequencer
`timescale 1ns/1ps

module ultrasonic_ranging_control_test;
  logic        clk_sys;
  logic        nrst;
  logic        cycleTrigger;
  logic        receiveInput;
  logic        blanking_override;
  logic        echo_rearm;
  logic        transducer_drive;
  logic        burst_clock_out;
  logic        echoDetected;
  logic        expQ[$];
  logic        lastFlag;
  logic [31:0] seed;
  int          badCount;
  int          checked;
  int          cycles;
  int          pulses;
  int          oscEdges;
  int          trigCyc;
  int          riseCyc;
  int          gap;
  int          echoLen;
  int          tofExp;

  urc_host_model hostU (.clk_sys(clk_sys), .cycleTrigger(cycleTrigger), .receiveInput(receiveInput),
                        .blanking_override(blanking_override), .echo_rearm(echo_rearm));

  urc_ranging_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .cycleTrigger(cycleTrigger),
                          .receiveInput(receiveInput), .blanking_override(blanking_override),
                          .echo_rearm(echo_rearm), .transducer_drive(transducer_drive),
                          .burst_clock_out(burst_clock_out), .echoDetected(echoDetected));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  function automatic int nextLen();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return 1 + int'(seed[2:0]);
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, badCount);
    if (badCount == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge transducer_drive) pulses++;
  always @(burst_clock_out) oscEdges++;

  // hang guard: the planned sequence needs about 82k cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      badCount++;
      tally_and_finish();
    end
  end

  // every flag change must match the oldest expected note
  always @(negedge clk_sys) begin
    if (nrst === 1'b1 && echoDetected !== lastFlag) begin
      lastFlag = echoDetected;
      if (echoDetected === 1'b1) riseCyc = cycles;
      if (expQ.size() == 0) check("unexpected flag", 16'h0000, 16'h0001);
      else check("echoDetected", {15'h0000, expQ.pop_front()}, {15'h0000, echoDetected});
    end
  end

  initial begin
    nrst = 1'b0;
    lastFlag = 1'b0;
    seed = 32'h01dac03b;
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    nrst = 1'b1;
    hostU.settle();
    pulses = 0;
    oscEdges = 0;
    hostU.trig(!cycleTrigger);
    hostU.idle(9000 + nextLen());
    check("burst pulses", 16'h0010, pulses[15:0]);
    check("osc running", 16'h0001, {15'h0000, oscEdges >= 30});
    hostU.echo(nextLen()); // still blanked
    hostU.override(!blanking_override);
    expQ.push_back(1'b1);
    hostU.echo(nextLen());
    hostU.idle(40 + nextLen());
    expQ.push_back(1'b0);
    hostU.rearm(11000 + 2 * nextLen());
    expQ.push_back(1'b1);
    hostU.echo(nextLen());
    hostU.idle(40 + nextLen());
    expQ.push_back(1'b0);
    hostU.trig(!cycleTrigger);
    hostU.override(!blanking_override);
    hostU.idle(4 + nextLen());
    oscEdges = 0;
    hostU.idle(1000 + nextLen());
    check("osc stopped", 16'h0000, oscEdges[15:0]);
    // blanking timed from the rise: 118 osc periods of 506 clocks
    hostU.trig(!cycleTrigger);
    trigCyc = cycles;
    gap = 59400 + nextLen();
    hostU.idle(gap);
    echoLen = nextLen();
    hostU.echo(echoLen);
    // flag seen one negedge after the sampled echo, counted from the trigger negedge
    tofExp = gap + echoLen + 3;
    gap = 800 + nextLen();
    hostU.idle(gap);
    tofExp = tofExp + gap;
    expQ.push_back(1'b1);
    hostU.echo(nextLen());
    hostU.idle(40 + nextLen());
    check("time of flight", 16'(tofExp), 16'(riseCyc - trigCyc));
    expQ.push_back(1'b0);
    hostU.trig(!cycleTrigger);
    hostU.idle(8 + nextLen());
    check("pending notes", 16'h0000, 16'(expQ.size()));
    tally_and_finish();
  end
endmodule // ultrasonic_ranging_control_test
